// *** design/osp_output_stage.sv ***
// osp_output_stage: sync front end, colour mapping, row latches and control registers
// assumes sync pins asynchronous to pclk, pixel stream and vector acknowledge on pclk
//
// Operation
// - row attribute latches clear to zero at each vertical scan start.
// - every new-row character outside a vertical scan start advances the screen row by one.
// - split background space applies new background at the cell midpoint.
// - ordinary space leaves stored background colour alone.
// - background colour survives vertical scans, never cleared per field.
// - background space updates colour only in display mode one or higher.
// - pixel one shows foreground and overlay active; zero shows background and, in mode two, enable.
// - in modes two and three colour outputs hold background except syncs, foreground pixels, shadow bits.
// - interrupt flag sets on vsync leading edge, clears when vectored.
// - software writing the flag sets or clears it directly.
// - vsync polarity bit selects input sense and flag edge.
// - during active vsync colours are black and overlay control inactive.
// - vertical start counter clears on vsync leading or trailing edge.
// - hsync polarity bit selects horizontal sync input sense.
// - overlay control polarity bit selects active high or low.
// - code zero is black; colour polarity bit inverts pin levels.
// - vertical doubling draws double height, normal width.
// - vertical start counts hsync units regardless of doubling.
// - fg/bg output low on foreground bits when enabled, else high.
// - single-bit writes to other bits never touch the interrupt flag.
// - mode zero stops oscillator, blacks colours, holds overlay inactive.
`timescale 1ns/1ps
module osp_output_stage #(
	parameter int VCNT_W = 10,
	parameter int ROW_W = 5,
	parameter int LINE_W = 6
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [osp_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic hsync_pin,
	input wire logic vsync_pin,
	input wire osp_pkg::osp_pix_t pix,
	input wire logic irq_ack,
	output logic irq_req,
	output logic [2:0] colour_outputs,
	output logic overlay_ctrl_out,
	output logic fg_bg_out,
	output logic pixel_oscillator_en,
	output logic [VCNT_W-1:0] vertical_start_value,
	output logic [ROW_W-1:0] screen_row,
	output logic [LINE_W-1:0] glyph_line
);
	logic [7:0] ctrl_reg;
	logic [1:0] mode_reg;
	logic hs_s1_reg, hs_s2_reg, vs_s1_reg, vs_s2_reg;
	logic hs_act_d_reg, vs_act_d_reg;
	logic [3:0] attr_reg;
	logic [2:0] bg_col_reg, pend_col_reg;
	logic bg_en_reg, pend_en_reg, split_pend_reg;
	logic [VCNT_W-1:0] vcnt_reg;
	logic [ROW_W-1:0] row_reg;
	logic [LINE_W-1:0] line_reg, gl_reg;
	logic [2:0] col_reg;
	logic ctl_reg, bf_reg, osc_reg;
	logic [31:0] prdata_reg;
	logic pready_reg, pslverr_reg;

	// apb decode
	wire setup = psel & ~penable;
	wire xfer = psel & penable & pready_reg;
	wire wr = xfer & pwrite;
	wire sel_ctrl = paddr == osp_pkg::ADDR_CTRL;
	wire sel_mode = paddr == osp_pkg::ADDR_MODE;
	wire sel_bitop = paddr == osp_pkg::ADDR_BITOP;
	wire sel_stat = paddr == osp_pkg::ADDR_STAT;
	wire mapped = sel_ctrl | sel_mode | sel_bitop | sel_stat;
	wire wr_ctrl = wr & sel_ctrl;
	wire wr_bitop = wr & sel_bitop;
	wire [osp_pkg::BITOP_IDX_W-1:0] bit_idx =
		pwdata[osp_pkg::BITOP_IDX_LSB +: osp_pkg::BITOP_IDX_W];
	wire bit_val = pwdata[osp_pkg::BITOP_VAL];
	wire [31:0] rd_mux =
		sel_ctrl ? {24'h000000, ctrl_reg} :
		sel_mode ? {30'h0, mode_reg} :
		sel_stat ? (32'(attr_reg) << osp_pkg::STAT_ATTR_LSB) |
			(32'(row_reg) << osp_pkg::STAT_ROW_LSB) | 32'(vcnt_reg) :
		32'h00000000;

	// control fields
	wire vpol = ctrl_reg[osp_pkg::BIT_VPOL];
	wire vedge = ctrl_reg[osp_pkg::BIT_VEDGE];
	wire hpol = ctrl_reg[osp_pkg::BIT_HPOL];
	wire cpol = ctrl_reg[osp_pkg::BIT_CPOL];
	wire opol = ctrl_reg[osp_pkg::BIT_OPOL];
	wire vdbl = ctrl_reg[osp_pkg::BIT_VDBL];
	wire bfe = ctrl_reg[osp_pkg::BIT_BFE];
	wire flag = ctrl_reg[osp_pkg::BIT_FLAG];

	// sync sense and edges
	wire hs_act = hs_s2_reg ^ hpol;
	wire vs_act = vs_s2_reg ^ vpol;
	wire hs_lead = hs_act & ~hs_act_d_reg;
	wire vs_lead = vs_act & ~vs_act_d_reg;
	wire vs_trail = ~vs_act & vs_act_d_reg;
	wire vclr = vedge ? vs_trail : vs_lead;

	// per-bit control next values; the flag is handled apart
	logic [7:0] ctrl_next;
	genvar gi;
	generate
		for (gi = 0; gi < osp_pkg::BIT_FLAG; gi++) begin : g_ctrl
			assign ctrl_next[gi] = wr_ctrl ? pwdata[gi] :
				(wr_bitop && bit_idx == osp_pkg::BITOP_IDX_W'(gi)) ? bit_val : ctrl_reg[gi];
		end
	endgenerate
	// only a write that names the flag or a vector may move it; such a write beats the vector, the hardware set wins
	wire bitop_flag = wr_bitop & (bit_idx == osp_pkg::BITOP_FLAG_IDX);
	wire flag_sw = wr_ctrl ? pwdata[osp_pkg::BIT_FLAG] : bitop_flag ? bit_val : flag;
	assign ctrl_next[osp_pkg::BIT_FLAG] = vs_lead | (flag_sw & ~(irq_ack & ~wr_ctrl & ~bitop_flag));
	wire [1:0] mode_next = (wr & sel_mode) ? pwdata[1:0] : mode_reg;

	// character stream decode
	wire is_norm = pix.valid & (pix.kind == osp_pkg::OSP_CHAR_NORMAL);
	wire is_nl = pix.valid & (pix.kind == osp_pkg::OSP_CHAR_NEWLINE);
	wire is_bsp = pix.valid & (pix.kind == osp_pkg::OSP_CHAR_BACKGROUND_SPACE_CHAR);
	wire is_split = pix.valid & (pix.kind == osp_pkg::OSP_CHAR_SPLIT);
	wire osd_run = mode_reg != osp_pkg::MODE_OFF;
	wire ended = attr_reg[3];
	wire split_apply = split_pend_reg & pix.cell_mid;

	// background colour: space passes through untouched, never cleared per field
	wire [2:0] bg_col_next = (is_bsp & osd_run) ? pix.colour :
		split_apply ? pend_col_reg : bg_col_reg;
	wire bg_en_next = (is_bsp & osd_run) ? pix.bg_en : split_apply ? pend_en_reg : bg_en_reg;
	wire split_pend_next = (is_split & osd_run) | (split_pend_reg & ~pix.cell_mid);
	wire [2:0] pend_col_next = is_split ? pix.colour : pend_col_reg;
	wire pend_en_next = is_split ? pix.bg_en : pend_en_reg;

	// row latches, clear at scan start wins over a new line in the same cycle
	wire [3:0] attr_next = vs_lead ? osp_pkg::ATTR_CLEAR :
		is_nl ? {pix.end_row, pix.reduced, pix.dbl, pix.outline} : attr_reg;
	wire [ROW_W-1:0] row_next = vs_lead ? '0 : is_nl ? row_reg + 1'b1 : row_reg;
	wire [LINE_W-1:0] line_next = (vs_lead | is_nl) ? '0 : hs_lead ? line_reg + 1'b1 : line_reg;
	wire tall = vdbl | attr_reg[1];
	wire [LINE_W-1:0] gl_next = tall ? line_reg >> 1 : line_reg;
	wire [VCNT_W-1:0] vcnt_next = vclr ? '0 : hs_lead ? vcnt_reg + 1'b1 : vcnt_reg;

	// pixel mapping
	wire show = (mode_reg == osp_pkg::MODE_SHOW) | (mode_reg == osp_pkg::MODE_FILL);
	wire blank = ~show | vs_act | hs_act;
	wire fg_px = is_norm & pix.bit_value & ~ended;
	wire drawn = pix.valid & ~is_nl & ~ended;
	wire [2:0] int_col = (pix.valid & pix.shadow) ? osp_pkg::COLOUR_BLACK :
		fg_px ? pix.colour : bg_col_reg;
	wire ctl_int = (mode_reg == osp_pkg::MODE_FILL) |
		(drawn & (pix.shadow | fg_px | bg_en_reg));
	wire [2:0] col_next = (blank ? osp_pkg::COLOUR_BLACK : int_col) ^ {3{opol}};
	wire ctl_next = (~blank & ctl_int) ^ cpol;
	wire bf_next = ~(bfe & fg_px & ~blank);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hs_s1_reg <= 1'b0;
			hs_s2_reg <= 1'b0;
			vs_s1_reg <= 1'b0;
			vs_s2_reg <= 1'b0;
			hs_act_d_reg <= 1'b0;
			vs_act_d_reg <= 1'b0;
		end else begin
			hs_s1_reg <= hsync_pin;
			hs_s2_reg <= hs_s1_reg;
			vs_s1_reg <= vsync_pin;
			vs_s2_reg <= vs_s1_reg;
			hs_act_d_reg <= hs_act;
			vs_act_d_reg <= vs_act;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= osp_pkg::CTRL_RESET;
			mode_reg <= osp_pkg::MODE_OFF;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end else begin
			ctrl_reg <= ctrl_next;
			mode_reg <= mode_next;
			pready_reg <= setup;
			pslverr_reg <= setup & ~mapped;
			prdata_reg <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			attr_reg <= osp_pkg::ATTR_CLEAR;
			bg_col_reg <= osp_pkg::BG_COLOUR_RESET;
			bg_en_reg <= 1'b0;
			pend_col_reg <= osp_pkg::BG_COLOUR_RESET;
			pend_en_reg <= 1'b0;
			split_pend_reg <= 1'b0;
			row_reg <= '0;
			line_reg <= '0;
			gl_reg <= '0;
			vcnt_reg <= '0;
		end else begin
			attr_reg <= attr_next;
			bg_col_reg <= bg_col_next;
			bg_en_reg <= bg_en_next;
			pend_col_reg <= pend_col_next;
			pend_en_reg <= pend_en_next;
			split_pend_reg <= split_pend_next;
			row_reg <= row_next;
			line_reg <= line_next;
			gl_reg <= gl_next;
			vcnt_reg <= vcnt_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			col_reg <= osp_pkg::COLOUR_BLACK;
			ctl_reg <= 1'b0;
			bf_reg <= 1'b1;
			osc_reg <= 1'b0;
		end else begin
			col_reg <= col_next;
			ctl_reg <= ctl_next;
			bf_reg <= bf_next;
			osc_reg <= osd_run;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign irq_req = ctrl_reg[osp_pkg::BIT_FLAG];
	assign colour_outputs = col_reg;
	assign overlay_ctrl_out = ctl_reg;
	assign fg_bg_out = bf_reg;
	assign pixel_oscillator_en = osc_reg;
	assign vertical_start_value = vcnt_reg;
	assign screen_row = row_reg;
	assign glyph_line = gl_reg;

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	flag_set_a: assert property (vs_lead |=> irq_req) else $error("flag not set on vsync edge");
	flag_vector_a: assert property (irq_ack && !vs_lead && !wr_ctrl && !bitop_flag |=> !irq_req)
		else $error("flag not cleared on vector");
	flag_write_a: assert property (wr_ctrl && !vs_lead |=> irq_req == $past(pwdata[7]))
		else $error("flag write lost");
	bitop_keep_a: assert property (wr_bitop && !bitop_flag && !vs_lead && !irq_ack && !wr_ctrl
		|=> $stable(irq_req)) else $error("flag moved by other bit");
	latch_clear_a: assert property (vs_lead |=> attr_reg == osp_pkg::ATTR_CLEAR && row_reg == '0)
		else $error("row latches not cleared");
	row_step_a: assert property (is_nl && !vs_lead |=> row_reg == $past(row_reg) + 1'b1)
		else $error("row did not advance");
	vertical_start_value_clr_a: assert property (vclr |=> vertical_start_value == '0)
		else $error("vertical_start_value not cleared");
	vsync_black_a: assert property (vs_act |=> colour_outputs == {3{$past(opol)}}
		&& overlay_ctrl_out == $past(cpol)) else $error("outputs not blanked in vsync");
	mode_off_a: assert property (mode_reg == osp_pkg::MODE_OFF |=> !pixel_oscillator_en
		&& overlay_ctrl_out == $past(cpol)) else $error("mode zero not idle");
	space_keep_a: assert property (pix.valid && pix.kind == osp_pkg::OSP_CHAR_SPACE && !split_pend_reg
		|=> $stable(bg_col_reg)) else $error("space changed colour");
	bg_gate_a: assert property (!osd_run && !split_pend_reg |=> $stable(bg_col_reg))
		else $error("colour changed in mode zero");
	split_mid_a: assert property (split_pend_reg && pix.cell_mid && !is_bsp |=> bg_col_reg == $past(pend_col_reg))
		else $error("split colour not applied");
	fgbg_off_a: assert property (!bfe |=> fg_bg_out) else $error("fg/bg output not high");


	// bus answer timing
	apb_ready_a: assert property (setup
		|=> pready)
		else $error("no ready after setup");
	apb_err_a: assert property (setup && !mapped
		|=> pslverr && pready)
		else $error("unmapped access not refused");
	apb_idle_a: assert property (!setup
		|=> !pready && !pslverr)
		else $error("ready outside access");
	ctrl_keep_a: assert property (!wr_ctrl && !wr_bitop
		|=> $stable(ctrl_reg[6:0]))
		else $error("control changed without write");

	// interrupt flag
	flag_hold_a: assert property (!vs_lead && !irq_ack && !wr_ctrl && !bitop_flag
		|=> $stable(irq_req))
		else $error("flag moved with no cause");
	flag_bitop_a: assert property (bitop_flag && !vs_lead
		|=> irq_req == $past(bit_val))
		else $error("flag bit write lost");

	// counters and row latches
	vertical_start_value_step_a: assert property (hs_lead && !vclr
		|=> vertical_start_value == $past(vertical_start_value) + 1'b1)
		else $error("vertical_start_value did not count hsync");
	vertical_start_value_hold_a: assert property (!hs_lead && !vclr
		|=> $stable(vertical_start_value))
		else $error("vertical_start_value moved without hsync");
	vertical_start_value_lead_a: assert property (vs_lead && !vedge
		|=> vertical_start_value == '0)
		else $error("vertical_start_value not cleared on leading edge");
	vertical_start_value_trail_a: assert property (vs_trail && vedge
		|=> vertical_start_value == '0)
		else $error("vertical_start_value not cleared on trailing edge");
	row_hold_a: assert property (!is_nl && !vs_lead
		|=> $stable(screen_row))
		else $error("row moved without new line");
	glyph_tall_a: assert property (vdbl
		|=> glyph_line == ($past(line_reg) >> 1))
		else $error("doubled line not halved");
	glyph_norm_a: assert property (!vdbl && !attr_reg[1]
		|=> glyph_line == $past(line_reg))
		else $error("normal line altered");

	// background colour store
	bg_keep_a: assert property (!is_bsp && !split_apply
		|=> $stable(bg_col_reg))
		else $error("background changed without cause");
	bsp_load_a: assert property (is_bsp && osd_run
		|=> bg_col_reg == $past(pix.colour))
		else $error("background space not stored");

	// pixel mapping
	hs_blank_a: assert property (hs_act
		|=> colour_outputs == {3{$past(opol)}} && overlay_ctrl_out == $past(cpol))
		else $error("outputs not blanked in hsync");
	mode_one_a: assert property (mode_reg == osp_pkg::MODE_INT
		|=> colour_outputs == {3{$past(opol)}} && pixel_oscillator_en)
		else $error("mode one not black");
	osc_on_a: assert property (osd_run
		|=> pixel_oscillator_en)
		else $error("oscillator not running");
	fg_colour_a: assert property (show && !blank && fg_px && !pix.shadow
		|=> colour_outputs == ($past(pix.colour) ^ {3{$past(opol)}}))
		else $error("foreground colour wrong");
	fg_ctl_a: assert property (show && !blank && fg_px
		|=> overlay_ctrl_out == !$past(cpol))
		else $error("overlay not active on foreground");
	bg_colour_a: assert property (show && !blank && !fg_px && !(pix.valid && pix.shadow)
		|=> colour_outputs == ($past(bg_col_reg) ^ {3{$past(opol)}}))
		else $error("background colour wrong");
	bg_ctl_a: assert property (mode_reg == osp_pkg::MODE_SHOW && !blank && drawn && !fg_px && !pix.shadow
		|=> overlay_ctrl_out == ($past(bg_en_reg) ^ $past(cpol)))
		else $error("overlay not from background enable");
	shadow_black_a: assert property (show && !blank && pix.valid && pix.shadow
		|=> colour_outputs == {3{$past(opol)}})
		else $error("shadow bit not black");
	mode_fill_a: assert property (mode_reg == osp_pkg::MODE_FILL && !blank
		|=> overlay_ctrl_out == !$past(cpol))
		else $error("fill mode overlay inactive");
	fgbg_on_a: assert property (bfe && fg_px && !blank
		|=> !fg_bg_out)
		else $error("fg/bg output not low");
	fgbg_bg_a: assert property (bfe && !fg_px
		|=> fg_bg_out)
		else $error("fg/bg output low on background");

	frame_c: cover property (vs_lead ##[1:300] vclr);
	fill_c: cover property (mode_reg == osp_pkg::MODE_FILL && !blank);
	bitop_c: cover property (bitop_flag ##1 irq_req);
	split_c: cover property (is_split ##[1:20] split_apply);
	fg_c: cover property (show && fg_px && !blank);
endmodule

// *** design/osp_pkg.sv ***
// osp_pkg: constants, register map and pixel carrier for the osd sync and pixel output stage
// assumes an apb master with 32-bit data and a character generator on the same clock
package osp_pkg;
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h0c0;
	localparam logic [ADDR_W-1:0] ADDR_MODE = 12'h0c4;
	localparam logic [ADDR_W-1:0] ADDR_BITOP = 12'h0c8;
	localparam logic [ADDR_W-1:0] ADDR_STAT = 12'h0cc;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// control register bit positions
	localparam int BIT_FLAG = 7;
	localparam int BIT_VPOL = 6;
	localparam int BIT_VEDGE = 5;
	localparam int BIT_HPOL = 4;
	localparam int BIT_CPOL = 3;
	localparam int BIT_OPOL = 2;
	localparam int BIT_VDBL = 1;
	localparam int BIT_BFE = 0;
	// bit-operation register fields
	localparam int BITOP_IDX_LSB = 0;
	localparam int BITOP_IDX_W = 3;
	localparam int BITOP_VAL = 3;
	localparam logic [BITOP_IDX_W-1:0] BITOP_FLAG_IDX = 3'h7;
	// status register field positions
	localparam int STAT_ROW_LSB = 16;
	localparam int STAT_ATTR_LSB = 24;
	// display modes
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_INT = 2'h1;
	localparam logic [1:0] MODE_SHOW = 2'h2;
	localparam logic [1:0] MODE_FILL = 2'h3;
	localparam logic [2:0] COLOUR_BLACK = 3'h0;
	localparam logic [3:0] ATTR_CLEAR = 4'h0;
	localparam logic [2:0] BG_COLOUR_RESET = 3'h0;

	typedef enum logic [2:0] {
		OSP_CHAR_NORMAL,
		OSP_CHAR_NEWLINE,
		OSP_CHAR_SPACE,
		OSP_CHAR_BACKGROUND_SPACE_CHAR,
		OSP_CHAR_SPLIT
	} osp_char_t;

	typedef struct packed {
		logic valid;
		logic bit_value;
		osp_char_t kind;
		logic bg_en;
		logic [2:0] colour;
		logic end_row;
		logic reduced;
		logic dbl;
		logic outline;
		logic cell_mid;
		logic shadow;
	} osp_pix_t;
endpackage

// *** tb/osp_tv_model.sv ***
// osp_tv_model: receiver side, makes the sync pins and reads the overlay control output
// assumes sync requests and polarity choices come from the bench on pclk
`timescale 1ns/1ps
module osp_tv_model (
	input wire logic vs_act,
	input wire logic hs_act,
	input wire logic vpol,
	input wire logic hpol,
	input wire logic pcl,
	input wire logic overlay_ctrl_out,
	output logic vsync_pin,
	output logic hsync_pin,
	output logic shown
);
	// pin level is the active level flipped by the chosen polarity
	assign vsync_pin = vs_act ^ vpol;
	assign hsync_pin = hs_act ^ hpol;
	// receiver switches to overlay colour while this is high
	assign shown = overlay_ctrl_out ^ pcl;
endmodule

// *** tb/testbench.sv ***
// testbench: directed tests of the osd sync and pixel output stage
// assumes osp_pkg compiled first, apb master and pixel stream driven here
`timescale 1ns/1ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin n_errors++; $display("Error %s exp %h got %h", n, e, a); end end
module testbench;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic hs = 1'b0, vs = 1'b0, vpol = 1'b0, hpol = 1'b0, pcl = 1'b0, irq_ack = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, hsync_pin, vsync_pin, shown, irq_req, ovl, fgbg, osc;
	logic [2:0] col;
	logic [9:0] vsv, v0;
	logic [4:0] row;
	logic [5:0] gl;
	osp_pkg::osp_pix_t pix = '0;
	int n_errors = 0, samples_checked = 0, cyc = 0;
	always #50 pclk = ~pclk;
	osp_output_stage osp_output_stage_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hsync_pin(hsync_pin), .vsync_pin(vsync_pin), .pix(pix), .irq_ack(irq_ack), .irq_req(irq_req),
		.colour_outputs(col), .overlay_ctrl_out(ovl), .fg_bg_out(fgbg), .pixel_oscillator_en(osc),
		.vertical_start_value(vsv), .screen_row(row), .glyph_line(gl));
	osp_tv_model osp_tv_model_inst (.vs_act(vs), .hs_act(hs), .vpol(vpol), .hpol(hpol), .pcl(pcl),
		.overlay_ctrl_out(ovl), .vsync_pin(vsync_pin), .hsync_pin(hsync_pin), .shown(shown));
	task test_done;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			test_done;
		end
	end
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			n_errors++;
			test_done;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task ctrl(input logic [7:0] v);
		apb(1'b1, osp_pkg::ADDR_CTRL, {24'h0, v});
	endtask
	task px(input osp_pkg::osp_char_t k, input logic b, input logic [2:0] c, input logic m, input logic [3:0] at);
		osp_pkg::osp_pix_t p;
		p = '0;
		p.valid = 1'b1;
		p.bit_value = b;
		p.kind = k;
		p.bg_en = 1'b1;
		p.colour = c;
		{p.end_row, p.reduced, p.dbl, p.outline} = at;
		p.cell_mid = m;
		@(posedge pclk);
		pix <= p;
		@(posedge pclk);
		pix <= '0;
		#1;
	endtask
	task sig(input logic v, input logic h);
		@(posedge pclk);
		vs <= v;
		hs <= h;
		repeat (6) @(posedge pclk);
		#1;
	endtask
	task t_reset;
		apb(1'b0, osp_pkg::ADDR_CTRL, 32'h0);
		`CHK("ctrl", 32'h0, rd)
		`CHK("col", 3'h0, col)
		`CHK("ovl", 1'b0, ovl)
		`CHK("fgbg", 1'b1, fgbg)
		`CHK("osc", 1'b0, osc)
		apb(1'b0, 12'h0d0, 32'h0);
		`CHK("slverr", 1'b1, er)
		$display("t_reset done");
	endtask
	task t_pix;
		int k;
		apb(1'b1, osp_pkg::ADDR_MODE, 32'h1);
		px(osp_pkg::OSP_CHAR_BACKGROUND_SPACE_CHAR, 1'b0, 3'h3, 1'b0, 4'h0);
		apb(1'b1, osp_pkg::ADDR_MODE, 32'h2);
		`CHK("osc", 1'b1, osc)
		px(osp_pkg::OSP_CHAR_NORMAL, 1'b0, 3'h1, 1'b0, 4'h0);
		`CHK("bg", 3'h3, col)
		px(osp_pkg::OSP_CHAR_SPACE, 1'b0, 3'h5, 1'b0, 4'h0);
		px(osp_pkg::OSP_CHAR_NORMAL, 1'b0, 3'h1, 1'b0, 4'h0);
		`CHK("bg", 3'h3, col)
		for (k = 0; k < 4; k++) begin
			pcl = k[1];
			ctrl({4'h0, k[1], k[0], 1'b0, k[1]});
			px(osp_pkg::OSP_CHAR_NORMAL, 1'b1, 3'h5, 1'b0, 4'h0);
			`CHK("fg", 3'h5 ^ {3{k[0]}}, col)
			`CHK("ovl", 1'b1 ^ k[1], ovl)
			`CHK("shown", 1'b1, shown)
			`CHK("fgbg", ~k[1], fgbg)
			px(osp_pkg::OSP_CHAR_NORMAL, 1'b0, 3'h5, 1'b0, 4'h0);
			`CHK("bg", 3'h3 ^ {3{k[0]}}, col)
			`CHK("fgbg", 1'b1, fgbg)
		end
		pcl = 1'b0;
		ctrl(8'h00);
		px(osp_pkg::OSP_CHAR_SPLIT, 1'b0, 3'h6, 1'b0, 4'h0);
		px(osp_pkg::OSP_CHAR_NORMAL, 1'b0, 3'h1, 1'b0, 4'h0);
		`CHK("split", 3'h3, col)
		px(osp_pkg::OSP_CHAR_NORMAL, 1'b0, 3'h1, 1'b1, 4'h0);
		px(osp_pkg::OSP_CHAR_NORMAL, 1'b0, 3'h1, 1'b0, 4'h0);
		`CHK("split", 3'h6, col)
		hpol = 1'b1;
		ctrl(8'h10);
		sig(1'b0, 1'b1);
		px(osp_pkg::OSP_CHAR_NORMAL, 1'b1, 3'h5, 1'b0, 4'h0);
		`CHK("hblank", 3'h0, col)
		sig(1'b0, 1'b0);
		px(osp_pkg::OSP_CHAR_NORMAL, 1'b1, 3'h5, 1'b0, 4'h0);
		`CHK("fg", 3'h5, col)
		hpol = 1'b0;
		ctrl(8'h00);
		sig(1'b1, 1'b0);
		sig(1'b0, 1'b0);
		px(osp_pkg::OSP_CHAR_NORMAL, 1'b0, 3'h1, 1'b0, 4'h0);
		`CHK("bg", 3'h6, col)
		$display("t_pix done");
	endtask
	task t_rows;
		sig(1'b1, 1'b0);
		sig(1'b0, 1'b0);
		`CHK("row", 5'h0, row)
		px(osp_pkg::OSP_CHAR_NEWLINE, 1'b0, 3'h0, 1'b0, 4'h6);
		`CHK("row", 5'h1, row)
		apb(1'b0, osp_pkg::ADDR_STAT, 32'h0);
		`CHK("attr", 4'h6, rd[27:24])
		px(osp_pkg::OSP_CHAR_NEWLINE, 1'b0, 3'h0, 1'b0, 4'h0);
		`CHK("row", 5'h2, row)
		ctrl(8'h02);
		sig(1'b1, 1'b0);
		apb(1'b0, osp_pkg::ADDR_STAT, 32'h0);
		`CHK("attr", 4'h0, rd[27:24])
		`CHK("row", 5'h0, row)
		sig(1'b0, 1'b0);
		v0 = vsv;
		repeat (3) begin
			sig(1'b0, 1'b1);
			sig(1'b0, 1'b0);
		end
		`CHK("vertical_start_value", v0 + 10'h3, vsv)
		`CHK("glyph", 6'h1, gl)
		ctrl(8'h22);
		sig(1'b1, 1'b0);
		`CHK("vertical_start_value", v0 + 10'h3, vsv)
		sig(1'b0, 1'b0);
		`CHK("vertical_start_value", 10'h0, vsv)
		$display("t_rows done");
	endtask
	task t_flag;
		ctrl(8'h00);
		`CHK("irq", 1'b0, irq_req)
		sig(1'b1, 1'b0);
		`CHK("irq", 1'b1, irq_req)
		@(posedge pclk);
		irq_ack <= 1'b1;
		@(posedge pclk);
		irq_ack <= 1'b0;
		#1;
		`CHK("irq", 1'b0, irq_req)
		sig(1'b0, 1'b0);
		ctrl(8'h80);
		`CHK("irq", 1'b1, irq_req)
		apb(1'b1, osp_pkg::ADDR_BITOP, 32'h9);
		apb(1'b0, osp_pkg::ADDR_CTRL, 32'h0);
		`CHK("ctrl", 32'h82, rd)
		ctrl(8'h00);
		apb(1'b1, osp_pkg::ADDR_BITOP, 32'hf);
		`CHK("irq", 1'b1, irq_req)
		vpol = 1'b1;
		ctrl(8'h40);
		repeat (6) @(posedge pclk);
		ctrl(8'h40);
		sig(1'b1, 1'b0);
		`CHK("irq", 1'b1, irq_req)
		px(osp_pkg::OSP_CHAR_NORMAL, 1'b1, 3'h5, 1'b0, 4'h0);
		`CHK("vblank", 3'h0, col)
		`CHK("ovl", 1'b0, ovl)
		sig(1'b0, 1'b0);
		$display("t_flag done");
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_pix;
		t_rows;
		t_flag;
		test_done;
	end
endmodule
